/* core/npc_defines.vh */
// constants for the oscillator word and loop configuration register bank
`ifndef NPC_DEFINES_VH
`define NPC_DEFINES_VH

// register indices; byte address is four times the index
`define NPC_IDX_PHASE_OFS   6'h12
`define NPC_IDX_RSVD_A      6'h13
`define NPC_IDX_FREQ_LO     6'h14
`define NPC_IDX_FREQ_HI     6'h15
`define NPC_IDX_RSVD_B      6'h16
`define NPC_IDX_RSVD_C      6'h17
`define NPC_IDX_LOOP_CTL    6'h18
`define NPC_IDX_LOOP_DIV    6'h19
`define NPC_IDX_VCO_TUNE    6'h1A
`define NPC_IDX_SYNC_CTL    6'h20

// reset values
`define NPC_RST_ZERO        16'h0000
`define NPC_RST_LOOP_CTL    16'h2808
`define NPC_RST_LOOP_DIV    16'h0440
`define NPC_RST_VCO_TUNE    16'h0020

// loop control fields
`define NPC_LC_FILT_RST     12
`define NPC_LC_NDIV_SYNC    11
`define NPC_LC_PLL_EN       10
`define NPC_LC_CP_HI        7
`define NPC_LC_CP_LO        6
`define NPC_LC_PRE_HI       5
`define NPC_LC_PRE_LO       3
`define NPC_LC_LFV_HI       2
`define NPC_LC_LFV_LO       0

// loop divider fields
`define NPC_LD_M_HI         15
`define NPC_LD_M_LO         8
`define NPC_LD_N_HI         7
`define NPC_LD_N_LO         4
`define NPC_LD_BIAS_HI      3
`define NPC_LD_BIAS_LO      2

// vco coarse tuning field
`define NPC_VT_HI           15
`define NPC_VT_LO           10

// sync control fields
`define NPC_SC_AUTO_EN      0
`define NPC_SC_MANUAL       1

// charge pump codes
`define NPC_CP_NONE         2'h0
`define NPC_CP_SINGLE       2'h1
`define NPC_CP_DUAL         2'h3

// prescaler code that divides by eight
`define NPC_PRE_DIV8_CODE   3'h0
`define NPC_PRE_DIV8        4'h8

// axi responses
`define NPC_RESP_OKAY       2'h0
`define NPC_RESP_SLVERR     2'h2

`endif

/* core/npc_config_regs.v */
// oscillator frequency word and clock multiplier loop configuration bank
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "npc_defines.vh"
// Behaviour
// R01: 32-bit signed increment split across 0x14/0x15
// R02: one lsb steps sample rate over 2^32
// R03: halves apply together on phase offset write
// R04: filter reset bit clamps filter, falling restarts
// R05: divider sync bit routes sync to dividers
// R06: enable bit runs loop, clear bypasses it
// R07: pump code 00 none, 01 single, 11 dual
// R08: prescaler codes 2..7 divide, 000 by eight
// R09: loop filter voltage bits read only
// R10: software tunes vco until voltage 010..101
// R11: vco coarse tuning bits 15:10, reset zero
// R12: m top bit zero: m is low seven
// R13: m top bit one: m is twice low
// R14: n divider setting held at bits 7:4
// R15: software sets bias tuning to 01
// R16: divider register resets to 0x0440
// R17: factory registers reset zero, 0x18 top 001
module npc_config_regs #(
	parameter AW = 8                        // axi address width
) (
	input  wire        aclk,               // bank clock
	input  wire        aresetn,            // synchronous reset, active low
	input  wire [AW-1:0] s_axi_awaddr,     // write address
	input  wire        s_axi_awvalid,      // write address valid
	output reg         s_axi_awready,      // write address ready
	input  wire [31:0] s_axi_wdata,        // write data
	input  wire [3:0]  s_axi_wstrb,        // write byte strobes
	input  wire        s_axi_wvalid,       // write data valid
	output reg         s_axi_wready,       // write data ready
	output reg  [1:0]  s_axi_bresp,        // write response
	output reg         s_axi_bvalid,       // write response valid
	input  wire        s_axi_bready,       // write response ready
	input  wire [AW-1:0] s_axi_araddr,     // read address
	input  wire        s_axi_arvalid,      // read address valid
	output reg         s_axi_arready,      // read address ready
	output reg  [31:0] s_axi_rdata,        // read data
	output reg  [1:0]  s_axi_rresp,        // read response
	output reg         s_axi_rvalid,       // read data valid
	input  wire        s_axi_rready,       // read data ready
	input  wire        lvds_sync,          // sync pin from the data port
	input  wire [2:0]  loop_volt_in,       // loop filter voltage comparators
	output reg  [31:0] nco_freq_word,      // active frequency increment
	output reg  [15:0] nco_phase_offset,   // active phase offset
	output reg         nco_update,         // pulse when mixer settings load
	output reg         loop_filter_clamp,  // hold loop filter at ground
	output reg         pll_restart,        // one pulse on clamp release
	output reg         ndiv_sync,          // sync routed to n dividers
	output reg         pll_enable,         // loop running
	output reg         pll_bypass,         // loop bypassed
	output reg         pump_single,        // single charge pump on
	output reg         pump_dual,          // dual charge pump on
	output reg  [3:0]  prescale_ratio,     // prescaler divide ratio
	output reg  [7:0]  m_divide,           // decoded m divider value
	output reg         m_valid,            // m setting is a legal value
	output reg  [3:0]  n_setting,          // raw n divider setting
	output reg  [1:0]  vco_bias_tune,      // vco bias tuning bits
	output reg  [5:0]  vco_coarse          // vco coarse tuning bits
);

	// register storage
	reg [15:0] phase_ofs_q;                // staged phase offset
	reg [15:0] rsvd_a_q;                   // factory word a
	reg [15:0] freq_lo_q;                  // staged increment low half
	reg [15:0] freq_hi_q;                  // staged increment high half
	reg [15:0] rsvd_b_q;                   // factory word b
	reg [15:0] rsvd_c_q;                   // factory word c
	reg [15:0] loop_ctl_q;                 // loop control, bits 2:0 unused
	reg [15:0] loop_div_q;                 // loop dividers
	reg [15:0] vco_tune_q;                 // vco coarse tuning word
	reg [1:0]  sync_ctl_q;                 // auto-sync enable, manual bit
	reg        clamp_prev_q;               // last clamp bit, for the edge
	reg [2:0]  volt_s1_q;                  // voltage synchroniser stage one
	reg [2:0]  volt_s2_q;                  // voltage synchroniser stage two
	reg        sync_s1_q;                  // sync pin stage one
	reg        sync_s2_q;                  // sync pin stage two

	// bus side signals
	wire       wr_fire;                    // write address and data taken
	wire       rd_fire;                    // read address taken
	wire [5:0] wr_idx;                     // write register index
	wire [5:0] rd_idx;                     // read register index
	reg        wr_hit;                     // write index is mapped
	reg        rd_hit;                     // read index is mapped
	reg [15:0] rd_word;                    // read mux result
	reg        load_mixer;                 // staged words become active
	reg [15:0] wmask;                      // byte lanes as a bit mask

	assign wr_fire = s_axi_awready & s_axi_awvalid &
		s_axi_wready & s_axi_wvalid;
	assign rd_fire = s_axi_arready & s_axi_arvalid;
	assign wr_idx  = s_axi_awaddr[7:2];
	assign rd_idx  = s_axi_araddr[7:2];

	// lane mask: only the low two lanes carry register bits
	always @* begin
		wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	end

	// which indices exist
	always @* begin
		case (wr_idx)
			`NPC_IDX_PHASE_OFS, `NPC_IDX_RSVD_A, `NPC_IDX_FREQ_LO,
			`NPC_IDX_FREQ_HI, `NPC_IDX_RSVD_B, `NPC_IDX_RSVD_C,
			`NPC_IDX_LOOP_CTL, `NPC_IDX_LOOP_DIV, `NPC_IDX_VCO_TUNE,
			`NPC_IDX_SYNC_CTL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		case (rd_idx)
			`NPC_IDX_PHASE_OFS, `NPC_IDX_RSVD_A, `NPC_IDX_FREQ_LO,
			`NPC_IDX_FREQ_HI, `NPC_IDX_RSVD_B, `NPC_IDX_RSVD_C,
			`NPC_IDX_LOOP_CTL, `NPC_IDX_LOOP_DIV, `NPC_IDX_VCO_TUNE,
			`NPC_IDX_SYNC_CTL: rd_hit = 1'b1;
			default: rd_hit = 1'b0;
		endcase
	end

	// read mux; voltage bits come live from the synchroniser
	always @* begin
		case (rd_idx)
			`NPC_IDX_PHASE_OFS: rd_word = phase_ofs_q;
			`NPC_IDX_RSVD_A:    rd_word = rsvd_a_q;
			`NPC_IDX_FREQ_LO:   rd_word = freq_lo_q;
			`NPC_IDX_FREQ_HI:   rd_word = freq_hi_q;
			`NPC_IDX_RSVD_B:    rd_word = rsvd_b_q;
			`NPC_IDX_RSVD_C:    rd_word = rsvd_c_q;
			`NPC_IDX_LOOP_CTL:  rd_word = {loop_ctl_q[15:3],
				volt_s2_q};                        // [R09]
			`NPC_IDX_LOOP_DIV:  rd_word = loop_div_q;
			`NPC_IDX_VCO_TUNE:  rd_word = vco_tune_q;
			`NPC_IDX_SYNC_CTL:  rd_word = {14'h0000, sync_ctl_q};
			default:            rd_word = `NPC_RST_ZERO;
		endcase
	end

	// mixer load fires on a phase offset write with auto-sync on,
	// or on the manual bit; the halves alone never reach the mixer
	always @* begin
		load_mixer = 1'b0;
		if (wr_fire && wr_idx == `NPC_IDX_PHASE_OFS &&
			sync_ctl_q[`NPC_SC_AUTO_EN]) begin
			load_mixer = 1'b1;                     // [R03]
		end
		if (wr_fire && wr_idx == `NPC_IDX_SYNC_CTL &&
			s_axi_wstrb[0] && s_axi_wdata[`NPC_SC_MANUAL]) begin
			load_mixer = 1'b1;                     // [R03]
		end
	end

	// write channel: both ready together once both valids are seen,
	// so neither channel is taken alone and no skid buffer is needed
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `NPC_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				// take both, answer next
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= wr_hit ? `NPC_RESP_OKAY :
					`NPC_RESP_SLVERR;
			end else if (s_axi_awvalid && s_axi_wvalid &&
				!s_axi_bvalid && !s_axi_awready) begin
				// both offered and no answer pending
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one cycle of arready, then data held until taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `NPC_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {16'h0000, rd_word};
				s_axi_rresp   <= rd_hit ? `NPC_RESP_OKAY :
					`NPC_RESP_SLVERR;
			end else if (s_axi_arvalid && !s_axi_rvalid &&
				!s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// register writes with byte lanes; factory words reset to zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_ofs_q <= `NPC_RST_ZERO;
			rsvd_a_q    <= `NPC_RST_ZERO;       // [R17]
			freq_lo_q   <= `NPC_RST_ZERO;
			freq_hi_q   <= `NPC_RST_ZERO;
			rsvd_b_q    <= `NPC_RST_ZERO;       // [R17]
			rsvd_c_q    <= `NPC_RST_ZERO;       // [R17]
			loop_ctl_q  <= `NPC_RST_LOOP_CTL;   // [R17]
			loop_div_q  <= `NPC_RST_LOOP_DIV;   // [R16]
			vco_tune_q  <= `NPC_RST_VCO_TUNE;   // [R11]
			sync_ctl_q  <= 2'h0;
		end else begin
			// manual bit is self clearing
			sync_ctl_q[`NPC_SC_MANUAL] <= 1'b0;
			if (wr_fire) begin
				case (wr_idx)
					`NPC_IDX_PHASE_OFS: phase_ofs_q <=
						(phase_ofs_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_RSVD_A: rsvd_a_q <=
						(rsvd_a_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_FREQ_LO: freq_lo_q <=           // [R01]
						(freq_lo_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_FREQ_HI: freq_hi_q <=           // [R01]
						(freq_hi_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_RSVD_B: rsvd_b_q <=
						(rsvd_b_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_RSVD_C: rsvd_c_q <=
						(rsvd_c_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_LOOP_CTL: loop_ctl_q <=
						(loop_ctl_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_LOOP_DIV: loop_div_q <=
						(loop_div_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_VCO_TUNE: vco_tune_q <=
						(vco_tune_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
					`NPC_IDX_SYNC_CTL: begin
						if (s_axi_wstrb[0]) begin
							sync_ctl_q <= s_axi_wdata[1:0];
						end
					end
					default: begin
						// unmapped: nothing stored, slverr answered
					end
				endcase
			end
		end
	end

	// pin synchronisers: first stage feeds only the second
	always @(posedge aclk) begin
		if (!aresetn) begin
			volt_s1_q <= 3'h0;
			volt_s2_q <= 3'h0;
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
		end else begin
			volt_s1_q <= loop_volt_in;
			volt_s2_q <= volt_s1_q;                 // [R09]
			sync_s1_q <= lvds_sync;
			sync_s2_q <= sync_s1_q;
		end
	end

	// active mixer settings, loaded together from the staged words;
	// the word is signed, one lsb is one 2^32nd of the sample rate
	always @(posedge aclk) begin
		if (!aresetn) begin
			nco_freq_word    <= 32'h00000000;
			nco_phase_offset <= `NPC_RST_ZERO;
			nco_update       <= 1'b0;
		end else begin
			nco_update <= load_mixer;
			if (load_mixer) begin
				nco_freq_word    <= {freq_hi_q, freq_lo_q}; // [R01] [R02]
				// a phase write carries the new offset straight through
				nco_phase_offset <= (wr_idx == `NPC_IDX_PHASE_OFS) ?
					((phase_ofs_q & ~wmask) | (s_axi_wdata[15:0] & wmask)) :
					phase_ofs_q;                         // [R03]
			end
		end
	end

	// loop control decode, every output registered
	always @(posedge aclk) begin
		if (!aresetn) begin
			loop_filter_clamp <= 1'b0;
			clamp_prev_q      <= 1'b0;
			pll_restart       <= 1'b0;
			ndiv_sync         <= 1'b0;
			pll_enable        <= 1'b0;
			pll_bypass        <= 1'b1;
			pump_single       <= 1'b0;
			pump_dual         <= 1'b0;
			prescale_ratio    <= 4'h0;
		end else begin
			loop_filter_clamp <= loop_ctl_q[`NPC_LC_FILT_RST];  // [R04]
			clamp_prev_q      <= loop_ctl_q[`NPC_LC_FILT_RST];
			// falling clamp bit restarts the loop after a lock-up
			pll_restart <= clamp_prev_q &
				~loop_ctl_q[`NPC_LC_FILT_RST];                   // [R04]
			// sync pin gated through to the dividers when enabled
			ndiv_sync  <= loop_ctl_q[`NPC_LC_NDIV_SYNC] & sync_s2_q; // [R05]
			pll_enable <= loop_ctl_q[`NPC_LC_PLL_EN];            // [R06]
			pll_bypass <= ~loop_ctl_q[`NPC_LC_PLL_EN];           // [R06]
			// the unused code 10 leaves both pumps off
			case (loop_ctl_q[`NPC_LC_CP_HI:`NPC_LC_CP_LO])
				`NPC_CP_SINGLE: begin
					pump_single <= 1'b1;                          // [R07]
					pump_dual   <= 1'b0;
				end
				`NPC_CP_DUAL: begin
					pump_single <= 1'b0;
					pump_dual   <= 1'b1;                          // [R07]
				end
				default: begin
					pump_single <= 1'b0;                          // [R07]
					pump_dual   <= 1'b0;
				end
			endcase
			// code 001 has no ratio of its own; it passes as one
			if (loop_ctl_q[`NPC_LC_PRE_HI:`NPC_LC_PRE_LO] ==
				`NPC_PRE_DIV8_CODE) begin
				prescale_ratio <= `NPC_PRE_DIV8;                  // [R08]
			end else begin
				prescale_ratio <= {1'b0,
					loop_ctl_q[`NPC_LC_PRE_HI:`NPC_LC_PRE_LO]};   // [R08]
			end
		end
	end

	// divider and tuning decode
	always @(posedge aclk) begin
		if (!aresetn) begin
			m_divide      <= 8'h00;
			m_valid       <= 1'b0;
			n_setting     <= 4'h0;
			vco_bias_tune <= 2'h0;
			vco_coarse    <= 6'h00;
		end else begin
			if (loop_div_q[`NPC_LD_M_HI]) begin
				// doubled range: even values 8..254
				m_divide <= {loop_div_q[14:8], 1'b0};             // [R13]
				m_valid  <= (loop_div_q[14:8] >= 7'h04);         // [R13]
			end else begin
				m_divide <= {1'b0, loop_div_q[14:8]};             // [R12]
				m_valid  <= (loop_div_q[14:8] >= 7'h04);         // [R12]
			end
			n_setting     <= loop_div_q[`NPC_LD_N_HI:`NPC_LD_N_LO];      // [R14]
			vco_bias_tune <= loop_div_q[`NPC_LD_BIAS_HI:`NPC_LD_BIAS_LO];
			vco_coarse    <= vco_tune_q[`NPC_VT_HI:`NPC_VT_LO];          // [R11]
		end
	end

endmodule
`default_nettype wire

/* tb/npc_config_regs_props.sv */
// assertion checker for the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module npc_config_regs_props (
	input wire logic        aclk,              // bank clock
	input wire logic        aresetn,           // reset, active low
	input wire logic        s_axi_awvalid,     // write address valid
	input wire logic        s_axi_wvalid,      // write data valid
	input wire logic        s_axi_awready,     // write address ready
	input wire logic        s_axi_wready,      // write data ready
	input wire logic        s_axi_bvalid,      // write response valid
	input wire logic        s_axi_bready,      // write response ready
	input wire logic        s_axi_arvalid,     // read address valid
	input wire logic        s_axi_arready,     // read address ready
	input wire logic        s_axi_rvalid,      // read data valid
	input wire logic [31:0] nco_freq_word,     // active increment
	input wire logic        nco_update,        // mixer load pulse
	input wire logic        loop_filter_clamp, // filter held at ground
	input wire logic        pll_restart,       // restart pulse
	input wire logic        pll_enable,        // loop running
	input wire logic        pll_bypass,        // loop bypassed
	input wire logic        pump_single,       // single pump on
	input wire logic        pump_dual,         // dual pump on
	input wire logic [7:0]  m_divide,          // decoded m value
	input wire logic        m_valid            // m is legal
);
	// one clock domain, so clock and reset are given once here
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ready_pair: assert property (s_axi_awready |->
		s_axi_wready && s_axi_awvalid && s_axi_wvalid)
		else $error("write readies not paired with both valids");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write ready longer than one cycle");
	a_write_resp: assert property (s_axi_awready && s_axi_awvalid |=>
		s_axi_bvalid) else $error("no write response after take");
	a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("write response not retired");
	a_read_resp: assert property (s_axi_arready && s_axi_arvalid |=>
		s_axi_rvalid) else $error("no read data after take");
	a_freq_hold: assert property (
		!nco_update |-> $stable(nco_freq_word))
		else $error("frequency word moved without a load");
	a_restart_pulse: assert property (
		$fell(loop_filter_clamp) |-> pll_restart ##1 !pll_restart)
		else $error("no single restart pulse after clamp release");
	a_restart_cause: assert property (
		pll_restart |-> !loop_filter_clamp &&
		$past(loop_filter_clamp)) else $error("restart without release");
	a_bypass_inv: assert property (
		pll_bypass == !pll_enable) else $error("bypass not inverse");
	a_pump_excl: assert property (
		!(pump_single && pump_dual)) else $error("both pumps on");
	a_m_floor: assert property (
		m_valid |-> m_divide >= 8'h04) else $error("valid m below four");
	a_m_even: assert property (
		m_divide[7] |-> !m_divide[0]) else $error("large m is odd");
endmodule

bind npc_config_regs npc_config_regs_props u_props (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.nco_freq_word(nco_freq_word), .nco_update(nco_update),
	.loop_filter_clamp(loop_filter_clamp), .pll_restart(pll_restart),
	.pll_enable(pll_enable), .pll_bypass(pll_bypass),
	.pump_single(pump_single), .pump_dual(pump_dual),
	.m_divide(m_divide), .m_valid(m_valid));
`default_nettype wire

/* tb/npc_tb.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        aclk, aresetn;             // clock, reset active low
	logic [7:0]  aw_a, ar_a;                // byte addresses
	logic [31:0] w_d;                       // write data
	logic        aw_v, w_v, b_r, ar_v, r_r; // master handshakes
	logic        lvds_sync;                 // sync pin
	logic [2:0]  volt;                      // loop filter comparators
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v; // slave handshakes
	logic [1:0]  b_resp, r_resp, bias;      // responses, bias tuning
	logic [31:0] r_d, freq;                 // read data, active word
	logic [15:0] phase;                     // active phase offset
	logic        upd, clamp, restart, nsync, pen, pbyp, p1, p2, mval;
	logic [3:0]  pre, nset;                 // prescale ratio, n setting
	logic [7:0]  mdiv;                      // decoded m
	logic [5:0]  coarse;                    // vco coarse tuning
	int          failures, compares;        // verdict counters

	npc_config_regs dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
		.s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .lvds_sync(lvds_sync),
		.loop_volt_in(volt), .nco_freq_word(freq), .nco_phase_offset(phase),
		.nco_update(upd), .loop_filter_clamp(clamp), .pll_restart(restart),
		.ndiv_sync(nsync), .pll_enable(pen), .pll_bypass(pbyp),
		.pump_single(p1), .pump_dual(p2), .prescale_ratio(pre),
		.m_divide(mdiv), .m_valid(mval), .n_setting(nset),
		.vco_bias_tune(bias), .vco_coarse(coarse));

	// 50 ns period
	always #25 aclk = ~aclk;

	task automatic stop_test;
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// waits for one handshake signal, sampled at the edge, bounded
	task automatic await(input int k);
		int n;
		logic [3:0] s;
		n = 0;
		s = 4'h0;
		while (s[k] !== 1'b1 && n < 60) begin
			@(posedge aclk);
			s = {r_v, ar_rdy, b_v, aw_rdy};
			n++;
		end
		if (n >= 60) begin
			failures++;
			stop_test();
		end
	endtask

	// address and data offered together; bready simply stays high
	task automatic wr(input logic [5:0] i, input logic [15:0] d,
			input logic [1:0] er);
		aw_a <= {i, 2'h0};
		w_d <= {16'h0000, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		await(0);
		aw_v <= 1'b0;
		w_v <= 1'b0;
		await(1);
		chk("bresp", er, b_resp);
	endtask

	task automatic rd(input logic [5:0] i, input logic [31:0] e,
			input logic [1:0] er);
		ar_a <= {i, 2'h0};
		ar_v <= 1'b1;
		r_r <= 1'b1;
		await(2);
		ar_v <= 1'b0;
		await(3);
		chk("rdata", e, r_d);
		chk("rresp", er, r_resp);
	endtask

	task automatic t_reset;
		repeat (3) @(posedge aclk);
		chk("bypass", 32'h1, pbyp);
		chk("m", 32'h4, mdiv);
		chk("m valid", 32'h1, mval);
		for (int i = 8'h13; i <= 8'h17; i++)
			rd(i[5:0], 32'h0, 2'h0);
		rd(6'h18, 32'h280D, 2'h0);
		rd(6'h19, 32'h0440, 2'h0);
		rd(6'h1A, 32'h0020, 2'h0);
	endtask

	// negative word staged, then loaded by the phase write
	task automatic t_nco;
		wr(6'h14, 16'hBEEF, 2'h0);
		wr(6'h15, 16'h8001, 2'h0);
		repeat (3) @(posedge aclk);
		chk("freq staged", 32'h0, freq);
		wr(6'h20, 16'h0001, 2'h0);
		wr(6'h12, 16'h1234, 2'h0);
		chk("update", 32'h1, upd);
		repeat (3) @(posedge aclk);
		chk("update", 32'h0, upd);
		chk("freq", 32'h8001BEEF, freq);
		chk("phase", 32'h1234, phase);
		rd(6'h15, 32'h8001, 2'h0);
		// a low half alone stays staged; the manual strobe loads it
		wr(6'h14, 16'h0002, 2'h0);
		repeat (3) @(posedge aclk);
		chk("freq held", 32'h8001BEEF, freq);
		wr(6'h20, 16'h0003, 2'h0);
		chk("update", 32'h1, upd);
		@(posedge aclk);
		chk("freq manual", 32'h80010002, freq);
		chk("phase kept", 32'h1234, phase);
		rd(6'h20, 32'h1, 2'h0);
	endtask

	task automatic t_ctl;
		logic [15:0] d;
		wr(6'h18, 16'h3808, 2'h0);
		repeat (3) @(posedge aclk);
		chk("clamp", 32'h1, clamp);
		lvds_sync <= 1'b1;
		wr(6'h18, 16'h2C0F, 2'h0);
		@(posedge aclk);
		chk("restart", 32'h1, restart);
		repeat (3) @(posedge aclk);
		chk("restart", 32'h0, restart);
		chk("clamp", 32'h0, clamp);
		chk("sync", 32'h1, nsync);
		chk("enable", 32'h2, {pen, pbyp});
		rd(6'h18, 32'h2C0D, 2'h0);
		// every pump code and every prescaler code in one sweep
		for (int i = 0; i < 8; i++) begin
			d = {8'h20, i[1:0], i[2:0], 3'h0};
			wr(6'h18, d, 2'h0);
			repeat (3) @(posedge aclk);
			chk("pump", {i[1:0] == 2'h3, i[1:0] == 2'h1}, {p2, p1});
			chk("prescale", i[2:0] == 3'h0 ? 32'h8 : i[2:0], pre);
		end
		chk("sync off", 32'h0, nsync);
		chk("bypass", 32'h1, pbyp);
	endtask

	// m boundaries in both ranges, n and bias fields beside them
	task automatic t_div;
		logic [15:0] tab [6] = '{16'h0350, 16'h7FA4, 16'h8404,
			16'hFFF4, 16'h8300, 16'h0440};
		logic [7:0] m;
		foreach (tab[k]) begin
			m = tab[k][15] ? {tab[k][14:8], 1'b0} : {1'b0, tab[k][14:8]};
			wr(6'h19, tab[k], 2'h0);
			repeat (3) @(posedge aclk);
			chk("m", m, mdiv);
			chk("m valid", tab[k][14:8] >= 7'h04, mval);
			chk("n", tab[k][7:4], nset);
			chk("bias", tab[k][3:2], bias);
			rd(6'h19, tab[k], 2'h0);
		end
	endtask

	task automatic t_misc;
		wr(6'h1A, 16'hFC20, 2'h0);
		repeat (3) @(posedge aclk);
		chk("coarse", 32'h3F, coarse);
		wr(6'h16, 16'hA5A5, 2'h0);
		rd(6'h16, 32'hA5A5, 2'h0);
		wr(6'h3F, 16'h1111, 2'h2);
		rd(6'h3F, 32'h0, 2'h2);
		// reset in mid-run must bring the word back to zero
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("freq reset", 32'h0, freq);
		rd(6'h14, 32'h0, 2'h0);
		rd(6'h16, 32'h0, 2'h0);
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{aw_a, ar_a, w_d} = 48'h0;
		{aw_v, w_v, b_r, ar_v, r_r, lvds_sync} = 6'h0;
		volt = 3'h5; // inside the lock range
		failures = 0;
		compares = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_nco();
		t_ctl();
		t_div();
		t_misc();
		stop_test();
	end
endmodule
`default_nettype wire
